// ==== bench/adc_link_chk.sv ====
// Purpose: pin checks on the converter link
// Assumes: one clock, synchronous high reset
// Notes: sclk reaches the converter through a 3-edge sync
`timescale 1ns/1ps
`default_nettype none
module adc_link_chk (
  input wire logic REF_CLK, // clock
  input wire logic RST, // reset, high
  input wire logic sclk, // serial clock
  input wire logic [7:0] data_out, // data pins
  input wire logic strobe_out, // ready, low
  input wire logic strobe_oe_n, // ready enable, low
  input wire logic [2:0] format_sel // format pins
);
  localparam int CONV_LO = 256;
  logic [11:0] gap_q;
  logic [2:0] stab_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ****************
  // helpers
  // ****************
  // saturating, so a wait after sync cannot wrap
  always_ff @(posedge REF_CLK) begin
    if (RST || !$stable(format_sel)) stab_q <= 3'h0;
    else if (stab_q != 3'h7) stab_q <= stab_q + 3'h1;
    if (RST) gap_q <= 12'hFFF;
    else if ($fell(strobe_out)) gap_q <= 12'h001;
    else if (gap_q != 12'hFFF) gap_q <= gap_q + 12'h001;
  end
  // ****************
  // checks
  // ****************
  a_oe_spi: assert property (
    stab_q == 3'h7 |-> strobe_oe_n == !format_sel[0])
    else $error("ready enable wrong for format");
  a_sclk_wait: assert property (
    $fell(strobe_out) |-> !$rose(sclk) ##1 !$rose(sclk))
    else $error("sclk rose too soon after ready");
  a_sclk_high: assert property (
    $rose(sclk) |=> sclk [*3] ##1 !sclk)
    else $error("sclk high phase wrong");
  a_sclk_low: assert property ($fell(sclk) |=> !sclk [*3])
    else $error("sclk low phase too short");
  a_ready_hold: assert property (
    $fell(strobe_out) |=> !strobe_out [*4])
    else $error("ready released before sclk");
  a_ready_drop: assert property (
    $fell(sclk) && !strobe_out |-> ##[1:5] strobe_out)
    else $error("ready not released after sclk fall");
  a_msb_hold: assert property (
    $fell(strobe_out) |=> $stable(data_out) [*4])
    else $error("data moved before sclk fall");
  a_conv_gap: assert property (
    $fell(strobe_out) |-> gap_q >= CONV_LO)
    else $error("ready strobes closer than a period");
endmodule : adc_link_chk
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: both link ends joined, words and periods checked
// Assumes: SPI format, discrete and TDM layouts, host reads output one
// Notes: sample data only changes once a word is read
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LIMIT = 30000;
  logic REF_CLK;
  logic RST;
  logic [127:0] sample;
  logic [7:0] pd;
  logic dv;
  logic lp;
  logic run;
  logic [2:0] fmt;
  logic conv_done;
  logic test_mode;
  logic [7:0] chan_active;
  logic [15:0] word;
  logic word_valid;
  logic [15:0] exp_q[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  adc_link_if link();
  adc_device_end adc_device_end_i (.REF_CLK(REF_CLK), .RST(RST),
    .LINK(link.device), .SAMPLE_DATA(sample), .CONV_DONE(conv_done),
    .TEST_MODE(test_mode), .CHAN_ACTIVE(chan_active));
  adc_host_end adc_host_end_i (.REF_CLK(REF_CLK), .RST(RST),
    .LINK(link.host), .CFG_FORMAT(fmt), .CFG_DIV(dv),
    .CFG_LOW_POWER(lp), .CFG_PWDN(pd), .CFG_RUN(run), .WORD(word),
    .WORD_VALID(word_valid));
  adc_link_chk adc_link_chk_i (.REF_CLK(REF_CLK), .RST(RST),
    .sclk(link.sclk), .data_out(link.data_out),
    .strobe_out(link.strobe_out), .strobe_oe_n(link.strobe_oe_n),
    .format_sel(link.format_sel));
  // ****************
  // tasks
  // ****************
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val
  // pick 1 waits for a word, 0 for a conversion
  task automatic wait_for(input bit pick);
    do begin
      @(posedge REF_CLK);
      #1;
    end while ((pick ? word_valid : conv_done) !== 1'b1);
  endtask : wait_for
  task automatic run_mode(input logic [2:0] f, input logic d, input logic l,
      input logic [7:0] p, input int per);
    int t0;
    t0 = 0;
    @(posedge REF_CLK);
    run <= 1'b0;
    fmt <= f;
    dv <= d;
    lp <= l;
    pd <= p;
    repeat (8) @(posedge REF_CLK);
    run <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_for(1'b0);
      if (k > 0) cmp_val(32'(cyc - t0), 32'(per));
      t0 = cyc;
      // tdm: output one leads with the top channel's word
      exp_q.push_back(f[adc_link_pkg::FMT_DISCRETE_BIT] ?
                      (p[0] ? sample[15:0] : 16'h0000) :
                      (p[7] ? sample[127:112] : 16'h0000));
      wait_for(1'b1);
      @(posedge REF_CLK);
      sample <= {$urandom, $urandom, $urandom, $urandom};
    end
    @(posedge REF_CLK);
    cmp_val({24'h0, chan_active}, {24'h0, p});
    cmp_val({31'h0, test_mode}, 32'h0);
    cmp_val(32'(exp_q.size()), 32'h0);
    $display("mode fmt %0d div %0d low %0d done", f, d, l);
  endtask : run_mode
  // ****************
  // processes
  // ****************
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // a word with nothing noted counts as a miss
  always @(posedge REF_CLK) begin
    if (word_valid === 1'b1) begin
      if (exp_q.size() == 0)
        cmp_val(32'h0, 32'h1);
      else
        cmp_word(word, exp_q.pop_front());
    end
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("BAD t=%0t timeout", $time);
      close_out();
    end
  end
  initial begin
    RST = 1'b1;
    run = 1'b0;
    fmt = 3'h3;
    dv = 1'b1;
    lp = 1'b0;
    pd = 8'hFF;
    void'($urandom(53));
    sample = {$urandom, $urandom, $urandom, $urandom};
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    run_mode(3'h3, 1'b1, 1'b0, 8'hFF, adc_link_pkg::CONV_HS_DIV1);
    run_mode(3'h3, 1'b0, 1'b0, 8'hA4, adc_link_pkg::CONV_HS_DIV0);
    run_mode(3'h3, 1'b1, 1'b1, 8'h5B, adc_link_pkg::CONV_LP_DIV1);
    run_mode(3'h3, 1'b0, 1'b1, 8'hFF, adc_link_pkg::CONV_LP_DIV0);
    run_mode(3'h1, 1'b1, 1'b0, 8'h81, adc_link_pkg::CONV_HS_DIV1);
    run_mode(3'h1, 1'b1, 1'b0, 8'h7E, adc_link_pkg::CONV_HS_DIV1);
    close_out();
  end
endmodule : tb
`default_nettype wire

// ==== core/adc_device_end.sv ====
// Purpose: converter end: pin config, conversion timing, serial readout
// Assumes: sclk sampled into REF_CLK domain; REF_CLK stands for master clk
// Notes: results come from user port SAMPLE_DATA, latched at conversion end
//
// Summary of operation
// - divider pin picks master clock rate
// - mode pin 0 high speed, 1 low power
// - shared pin: ready out in SPI
// - format pins pick protocol and layout
// - TDM puts all channels on output one
// - discrete mode: each output own channel
// - unused outputs of small variant driven
// - each power-down pin gates its channel
// - device masks small variant's upper channels itself
// - test pins 00 normal, 11 test
// - one result per conversion period
// - ready falls on master clock edge
// - host waits one period before sclk
// - msb valid when ready falls
// - first sclk fall returns ready high
// - each sclk fall advances output bit
// - daisy input sampled on sclk fall
// - host keeps sclk period and phases
// - host keeps power-of-two sclk ratio
// - each result is sixteen bits
// - configuration from static pins only
`timescale 1ns/1ps
`default_nettype none
module adc_device_end #(
  parameter int CHAN = adc_link_pkg::CHANNELS,
  parameter int ACTIVE_CHAN = adc_link_pkg::CHANNELS,
  parameter int BITS = adc_link_pkg::WORD_BITS
) (
  input wire logic REF_CLK, // system and master clock
  input wire logic RST, // synchronous reset, high
  adc_link_if.device LINK, // pins to host
  input wire logic [CHAN*BITS-1:0] SAMPLE_DATA, // per-channel results
  output logic CONV_DONE, // pulse when a conversion completes
  output logic TEST_MODE, // test pins select test mode
  output logic [CHAN-1:0] CHAN_ACTIVE // channel powered
);
  if (ACTIVE_CHAN > CHAN || CHAN != 8 || BITS != 16) begin : g_bad_param
    $error("adc_device_end: unsupported parameters");
  end

  localparam int SH = CHAN * BITS;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [3:0] cfg_sync0;
    logic [3:0] cfg_sync1;
    logic [CHAN-1:0] pd_sync0;
    logic [CHAN-1:0] pd_sync1;
    logic [3:0] fmt_sync0;
    logic [3:0] fmt_sync1;
    logic [1:0] din_sync;
    logic [11:0] conv_cnt;
    logic ready_n;
    logic oe_n;
    logic [SH-1:0] shreg;
    logic [CHAN-1:0] dout;
    logic done;
    logic test;
    logic [CHAN-1:0] active;
  } state_t;

  state_t q, d;

  // ************************************************************
  // conversion period select
  // ************************************************************
  function automatic logic [11:0] conv_len(input logic lp, input logic div1);
    unique case ({lp, div1})
      2'h0: conv_len = 12'(adc_link_pkg::CONV_HS_DIV0);
      2'h1: conv_len = 12'(adc_link_pkg::CONV_HS_DIV1);
      2'h2: conv_len = 12'(adc_link_pkg::CONV_LP_DIV0);
      default: conv_len = 12'(adc_link_pkg::CONV_LP_DIV1);
    endcase
  endfunction : conv_len

  logic sclk_fall, spi_mode, discrete;
  logic [1:0] test_pins;
  logic [11:0] period;
  logic [CHAN-1:0] chan_ok;

  always_comb begin
    d = q;
    d.sclk_sync = {q.sclk_sync[1:0], LINK.sclk};
    d.cfg_sync0 = {LINK.clock_divider_select, LINK.speed_mode,
                   LINK.test_sel};
    d.cfg_sync1 = q.cfg_sync0;
    d.pd_sync0 = LINK.channel_power_down_pins;
    d.pd_sync1 = q.pd_sync0;
    d.fmt_sync0 = {LINK.sync_n, LINK.format_sel};
    d.fmt_sync1 = q.fmt_sync0;
    d.din_sync = {q.din_sync[0], LINK.daisy_in};
    sclk_fall = q.sclk_sync[2] & ~q.sclk_sync[1];
    spi_mode = q.fmt_sync1[adc_link_pkg::FMT_SPI_BIT];
    discrete = q.fmt_sync1[adc_link_pkg::FMT_DISCRETE_BIT];
    d.oe_n = ~spi_mode;
    test_pins = q.cfg_sync1[1:0];
    d.test = (test_pins == adc_link_pkg::TEST_ACTIVE);
    period = conv_len(q.cfg_sync1[2], q.cfg_sync1[3]);
    // per-channel power down, active low pin
    for (int i = 0; i < CHAN; i++) begin
      chan_ok[i] = q.pd_sync1[i] && (i < ACTIVE_CHAN);
    end
    d.active = chan_ok;
    d.done = 1'b0;
    // conversion period count; sync low restarts
    if (!q.fmt_sync1[3]) begin
      d.conv_cnt = 12'h000;
    end else if (q.conv_cnt >= period - 12'h001) begin
      d.conv_cnt = 12'h000;
      d.done = 1'b1;
    end else begin
      d.conv_cnt = q.conv_cnt + 12'h001;
    end
    if (q.done) begin
      for (int i = 0; i < CHAN; i++) begin
        d.shreg[i*BITS +: BITS] = chan_ok[i] ? SAMPLE_DATA[i*BITS +: BITS]
                                             : 16'h0000;
      end
      d.ready_n = ~spi_mode;
    end else if (sclk_fall) begin
      d.ready_n = 1'b1;
      if (discrete) begin
        for (int i = 0; i < CHAN; i++) begin
          d.shreg[i*BITS +: BITS] = {q.shreg[i*BITS +: BITS-1],
                                     (i == 0) ? q.din_sync[1] : 1'b0};
        end
      end else begin
        d.shreg = {q.shreg[SH-2:0], q.din_sync[1]};
      end
    end
    for (int i = 0; i < CHAN; i++) begin
      if (discrete) begin
        d.dout[i] = d.shreg[i*BITS + BITS - 1];
      end else begin
        d.dout[i] = (i == 0) ? d.shreg[SH-1] : 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= '0;
      q.ready_n <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign LINK.strobe_out = q.ready_n;
  assign LINK.strobe_oe_n = q.oe_n;
  assign LINK.data_out = q.dout;
  assign CONV_DONE = q.done;
  assign TEST_MODE = q.test;
  assign CHAN_ACTIVE = q.active;
endmodule : adc_device_end
`default_nettype wire

// ==== core/adc_host_end.sv ====
// Purpose: host end: drives config pins and reads sixteen-bit words
// Assumes: SPI discrete layout read on output one, one word per ready
// Notes: sclk from REF_CLK divider; ready and data are synced pins;
// each bit is taken at an sclk fall, before the device reacts to it
`timescale 1ns/1ps
`default_nettype none
module adc_host_end #(
  parameter int BITS = adc_link_pkg::WORD_BITS,
  parameter int HALF = adc_link_pkg::SCLK_HALF
) (
  input wire logic REF_CLK, // system clock
  input wire logic RST, // synchronous reset, high
  adc_link_if.host LINK, // pins to device
  input wire logic [2:0] CFG_FORMAT, // format pins
  input wire logic CFG_DIV, // divider select
  input wire logic CFG_LOW_POWER, // mode pin
  input wire logic [7:0] CFG_PWDN, // power-down pins
  input wire logic CFG_RUN, // release sync
  output logic [15:0] WORD, // received word
  output logic WORD_VALID // one-cycle pulse
);
  // below four cycles a new bit has not crossed both ends' syncs
  if (HALF < 4 || HALF > 15 || BITS != 16) begin : g_bad_param
    $error("adc_host_end: bad parameters");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_SHIFT = 2'h2
  } phase_t;

  typedef struct packed {
    logic [1:0] rdy_sync;
    logic [1:0] dat_sync;
    phase_t phase;
    logic [3:0] div;
    logic sclk;
    logic [4:0] bits;
    logic [15:0] shreg;
    logic [15:0] word;
    logic valid;
  } state_t;

  state_t q, d;

  always_comb begin
    d = q;
    d.rdy_sync = {q.rdy_sync[0], LINK.strobe_out};
    d.dat_sync = {q.dat_sync[0], LINK.data_out[0]};
    d.valid = 1'b0;
    unique case (q.phase)
      ST_IDLE: begin
        if (!q.rdy_sync[1]) begin
          d.phase = ST_WAIT;
          d.div = 4'h0;
        end
      end
      ST_WAIT: begin
        d.div = q.div + 4'h1;
        if (q.div >= 4'(HALF)) begin
          d.phase = ST_SHIFT;
          d.div = 4'h0;
          d.bits = 5'h00;
        end
      end
      default: begin
        d.div = q.div + 4'h1;
        if (q.div == 4'(HALF - 1)) begin
          d.div = 4'h0;
          d.sclk = ~q.sclk;
          // taken at the fall: the answer to the last fall has arrived,
          // the answer to this one is still five cycles away
          if (q.sclk) begin
            d.shreg = {q.shreg[14:0], q.dat_sync[1]};
            d.bits = q.bits + 5'h01;
            if (q.bits == 5'(BITS - 1)) begin
              d.phase = ST_IDLE;
              d.word = {q.shreg[14:0], q.dat_sync[1]};
              d.valid = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q <= '0;
      q.rdy_sync <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign LINK.sclk = q.sclk;
  assign LINK.daisy_in = 1'b0;
  assign LINK.strobe_in = 1'b0;
  assign LINK.clock_divider_select = CFG_DIV;
  assign LINK.speed_mode = CFG_LOW_POWER;
  assign LINK.format_sel = CFG_FORMAT;
  assign LINK.test_sel = adc_link_pkg::TEST_NORMAL;
  assign LINK.channel_power_down_pins = CFG_PWDN;
  assign LINK.sync_n = CFG_RUN;
  assign WORD = q.word;
  assign WORD_VALID = q.valid;
endmodule : adc_host_end
`default_nettype wire

// ==== core/adc_link_if.sv ====
// Purpose: pins between converter and host
// Assumes: host reads the shared strobe pin directly; checker tests its enable
// Notes: strobe output enable is active low
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic daisy_in;
  logic [7:0] data_out;
  logic strobe_out;
  logic strobe_oe_n;
  logic strobe_in;
  logic clock_divider_select;
  logic speed_mode;
  logic [2:0] format_sel;
  logic [1:0] test_sel;
  logic [7:0] channel_power_down_pins;
  logic sync_n;
  modport device (
    input sclk, daisy_in, strobe_in, clock_divider_select, speed_mode,
    input format_sel, test_sel, channel_power_down_pins, sync_n,
    output data_out, strobe_out, strobe_oe_n
  );
  modport host (
    output sclk, daisy_in, strobe_in, clock_divider_select, speed_mode,
    output format_sel, test_sel, channel_power_down_pins, sync_n,
    input data_out, strobe_out, strobe_oe_n
  );
endinterface : adc_link_if
`default_nettype wire

// ==== core/adc_link_pkg.sv ====
// Purpose: shared constants for the converter serial readout link
// Assumes: one system clock REF_CLK at 100 MHz
// Notes: conversion and sclk timing expressed in REF_CLK cycles
package adc_link_pkg;
  localparam int CHANNELS = 8;
  localparam int WORD_BITS = 16;
  // conversion period, in master clock periods
  localparam int CONV_HS_DIV1 = 256;
  localparam int CONV_HS_DIV0 = 512;
  localparam int CONV_LP_DIV1 = 1280;
  localparam int CONV_LP_DIV0 = 2560;
  localparam int CONV_MIN = 256;
  localparam int CONV_MAX = 2560;
  // least wait from ready strobe fall to first sclk rise, master periods
  localparam int READY_WAIT_MCLK = 1;
  // sclk half period in REF_CLK cycles (host divider); a bit needs six
  // cycles through both ends' syncs, so four is the least, ratio 1/8
  localparam int SCLK_HALF = 4;
  // format field positions
  localparam int FMT_SPI_BIT = 0;
  localparam int FMT_DISCRETE_BIT = 1;
  localparam int FMT_DYNAMIC_BIT = 2;
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_ACTIVE = 2'h3;
  localparam logic MODE_HIGH_SPEED = 1'h0;
  localparam logic MODE_LOW_POWER = 1'h1;
endpackage : adc_link_pkg
